//--- rtl/stlc_pkg.sv
// Package: constants and carrier types for the stairway light controller
package stlc_pkg;
  // Clock and tick timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_MS         = 10;   // Base tick of the timers
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_SEC   = 1000 / TICK_MS;
  localparam int unsigned SEC_PER_MIN     = 60;
  // Timer setpoints in their own units
  localparam int unsigned LONG_PRESS_S    = 5;
  localparam int unsigned AUTO_OFF_MIN    = 6;
  localparam int unsigned LIMIT_H         = 4;
  localparam int unsigned MIN_PER_H       = 60;
  localparam int unsigned MAX_SET_MIN     = 99 * 60 + 59;
  // Derived counts
  localparam int unsigned LONG_PRESS_TICKS = LONG_PRESS_S * TICKS_PER_SEC;
  localparam int unsigned MIN_TICKS        = SEC_PER_MIN * TICKS_PER_SEC;
  localparam int unsigned AUTO_OFF_MINS    = AUTO_OFF_MIN;
  localparam int unsigned LIMIT_MINS       = LIMIT_H * MIN_PER_H;
  localparam int unsigned MIN_W            = 14;   // Holds up to 99:59
  localparam int unsigned SUB_W            = 13;   // Ticks within a minute
  localparam int unsigned PRESS_W          = 10;

  // Status of one channel
  typedef struct packed {
    logic light;
    logic continuous;
  } stlc_chan_type;

  // Press tracker states
  typedef enum logic [1:0] {
    STLC_IDLE  = 2'b00,
    STLC_HELD  = 2'b01,
    STLC_LONG  = 2'b10
  } stlc_press_type;
endpackage

//--- rtl/stlc_channel.sv
// One stairway light channel: toggle, long press, auto-off and limit timers
`timescale 1ns/1ps
module stlc_channel
  import stlc_pkg::*;
#(
  parameter int unsigned AUTO_MINS  = AUTO_OFF_MINS,
  parameter int unsigned LIMIT_M    = LIMIT_MINS,
  parameter bit          USE_LIMIT  = 1'b1
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          tick,
  input  wire logic          min_tick,
  input  wire logic          button,
  output stlc_chan_type      state
);
  initial begin
    if (AUTO_MINS < 1 || AUTO_MINS > MAX_SET_MIN || LIMIT_M < 1 || LIMIT_M > MAX_SET_MIN)
      $error("Timer setpoint out of range");
  end

  logic                 button_q;
  logic                 light;
  logic                 continuous;
  logic [PRESS_W-1:0]   press_cnt;
  logic [MIN_W-1:0]     auto_cnt;
  logic [MIN_W-1:0]     limit_cnt;
  stlc_press_type       press_st;
  stlc_press_type       next_press_st;

  // Toggle pulse: one cycle on each new press, zero pulse time
  wire toggle_pulse = button & ~button_q;
  wire long_done    = (press_st == STLC_HELD) &&
                      (press_cnt == PRESS_W'(LONG_PRESS_TICKS));
  wire auto_run     = light & ~continuous;
  wire auto_done    = auto_run && (auto_cnt == MIN_W'(AUTO_MINS));
  wire limit_done   = USE_LIMIT && light &&
                      (limit_cnt == MIN_W'(LIMIT_M));
  wire next_light   = (light ^ toggle_pulse) & ~auto_done & ~limit_done;

  // Press tracker: long press latches until release so the flag sets once
  always_comb begin
    next_press_st = press_st;
    case (press_st)
      STLC_IDLE: if (button) next_press_st = STLC_HELD;
      STLC_HELD: begin
        if (!button) next_press_st = STLC_IDLE;
        else if (long_done) next_press_st = STLC_LONG;
      end
      STLC_LONG: if (!button) next_press_st = STLC_IDLE;
      default:   next_press_st = STLC_IDLE;
    endcase
  end

  // Edge register and press state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      button_q <= 1'b0;
      press_st <= STLC_IDLE;
    end else if (ce) begin
      button_q <= button;
      press_st <= next_press_st;
    end
  end

  // Press timer resets when the button is released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) press_cnt <= '0;
    else if (ce) begin
      if (press_st != STLC_HELD) press_cnt <= '0;
      else if (tick && !long_done) press_cnt <= press_cnt + 1'b1;
    end
  end

  // Minute timers, reset whenever their trigger is gone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_cnt  <= '0;
      limit_cnt <= '0;
    end else if (ce) begin
      // Clearing on the long press keeps no stale count once continuous light starts
      if (!auto_run || !next_light || long_done) auto_cnt <= '0;
      else if (min_tick) auto_cnt <= auto_cnt + 1'b1;
      if (!light || !next_light) limit_cnt <= '0;
      else if (min_tick) limit_cnt <= limit_cnt + 1'b1;
    end
  end

  // Light and flag; flag drops with the light
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      light      <= 1'b0;
      continuous <= 1'b0;
    end else if (ce) begin
      light <= next_light;
      if (!next_light) continuous <= 1'b0;
      else if (long_done) continuous <= 1'b1;
    end
  end

  assign state = '{light: light, continuous: continuous};

  AST_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && toggle_pulse && !auto_done && !limit_done |=> light != $past(light))
    else $error("Toggle did not invert light");
  AST_TOGGLE_CONT: assert property (@(posedge clk) disable iff (!rst_n)
    ce && toggle_pulse && light && continuous |=> !light)
    else $error("Toggle failed to end continuous light");
  AST_PULSE_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && toggle_pulse |=> !toggle_pulse)
    else $error("Toggle pulse longer than one cycle");
  AST_AUTO_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    ce && auto_done |=> !light)
    else $error("Auto-off did not switch light off");
  AST_CONT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    continuous |-> auto_cnt == '0)
    else $error("Auto-off timer ran in continuous mode");
  AST_LONG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    ce && long_done && next_light |=> continuous)
    else $error("Long press did not set flag");
  AST_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
    ce && limit_done |=> !light && !continuous)
    else $error("Limit did not end light");
  AST_FLAG_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    !light |-> !continuous)
    else $error("Flag set while light off");
  COV_TOGGLE: cover property (@(posedge clk) disable iff (!rst_n) ce && toggle_pulse);
  COV_LONG:   cover property (@(posedge clk) disable iff (!rst_n) ce && long_done);
  COV_AUTO:   cover property (@(posedge clk) disable iff (!rst_n) ce && auto_done);
endmodule // stlc_channel

//--- rtl/stlc_top.sv
// Four stairway light channels sharing one synchroniser set and tick base
`timescale 1ns/1ps
module stlc_top
  import stlc_pkg::*;
#(
  parameter int unsigned CHANNELS   = 4,
  parameter int unsigned TICK_DIV   = TICK_CYCLES,  // Shorten for simulation
  parameter int unsigned MIN_DIV    = MIN_TICKS,    // Ticks per minute
  parameter int unsigned AUTO_MINS  = AUTO_OFF_MINS,
  parameter int unsigned LIMIT_M    = LIMIT_MINS,
  parameter bit          USE_LIMIT  = 1'b1
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic [CHANNELS-1:0] pushbutton_input,
  output logic      [CHANNELS-1:0] light_output
);
  // Divider width follows the tick period so the full-speed default fits
  localparam int unsigned DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  initial begin
    if (CHANNELS < 1 || TICK_DIV < 1 ||
        MIN_DIV < 1 || MIN_DIV >= (1 << SUB_W))
      $error("Unsupported parameter value");
  end

  logic [CHANNELS-1:0] btn_meta;
  logic [CHANNELS-1:0] btn_sync;
  logic [DIV_W-1:0]    div_cnt;
  logic [SUB_W-1:0]    sub_cnt;
  logic                tick;
  logic                min_tick;
  stlc_chan_type       chan [CHANNELS];

  // Two-stage synchroniser on the asynchronous buttons
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_meta <= '0;
      btn_sync <= '0;
    end else if (ce) begin
      btn_meta <= pushbutton_input;
      btn_sync <= btn_meta;
    end
  end

  wire div_wrap = (div_cnt == DIV_W'(TICK_DIV - 1));
  wire sub_wrap = (sub_cnt == SUB_W'(MIN_DIV - 1));

  // Tick base: registered pulses so all channels see the same edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt  <= '0;
      sub_cnt  <= '0;
      tick     <= 1'b0;
      min_tick <= 1'b0;
    end else if (ce) begin
      div_cnt  <= div_wrap ? '0 : div_cnt + 1'b1;
      tick     <= div_wrap;
      min_tick <= div_wrap && sub_wrap;
      if (div_wrap) sub_cnt <= sub_wrap ? '0 : sub_cnt + 1'b1;
    end
  end

  // Independent channels
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    stlc_channel #(
      .AUTO_MINS (AUTO_MINS),
      .LIMIT_M   (LIMIT_M),
      .USE_LIMIT (USE_LIMIT)
    ) u_chan (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .tick     (tick),
      .min_tick (min_tick),
      .button   (btn_sync[i]),
      .state    (chan[i])
    );
    assign light_output[i] = chan[i].light;  // Straight from the light flop
  end

  AST_MIN_TICK: assert property (@(posedge clk) disable iff (!rst_n)
    min_tick |-> tick)
    else $error("Minute tick without base tick");
  COV_LIGHT: cover property (@(posedge clk) disable iff (!rst_n) light_output[0]);
endmodule // stlc_top

//--- tb/stlc_button_model.sv
// Partner model: momentary pushbuttons and lamp relays of the four channels
`timescale 1ns/1ps
module stlc_button_model
  import stlc_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
) (
  input  wire logic                clk,
  input  wire logic [CHANNELS-1:0] light_output,
  output logic      [CHANNELS-1:0] pushbutton_input
);
  initial pushbutton_input = '0;
  // Hold a button for some cycles, then leave it released long enough to sync
  task automatic press(input int ch, input int cyc);
    @(negedge clk);
    pushbutton_input[ch] = 1'b1;
    repeat (cyc) @(negedge clk);
    pushbutton_input[ch] = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Lamp side: count cycles until the relay drops, bounded so a hang is seen
  task automatic on_time(input int ch, input int lim, output int n);
    n = 0;
    while (light_output[ch] === 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
endmodule // stlc_button_model

//--- tb/tb_top.sv
// Self-checking testbench of the stairway light controller
`timescale 1ns/1ps
module tb_top;
  import stlc_pkg::*;
  localparam int MD = 8;    // Clocks per minute with the shortened dividers
  localparam int AM = 200;  // Auto-off minutes, above the long press span
  localparam int LM = 300;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic [3:0] pushbutton_input;
  logic [3:0] light_output;
  logic [3:0] exp_l;
  int         n_fail = 0;
  int         n_tests = 0;
  int         n;
  int         ch;
  always #50 clk = ~clk;
  stlc_top #(.TICK_DIV(2), .MIN_DIV(4), .AUTO_MINS(AM), .LIMIT_M(LM)) u_stlc_top (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .pushbutton_input(pushbutton_input), .light_output(light_output));
  stlc_button_model u_stlc_button_model (
    .clk(clk), .light_output(light_output), .pushbutton_input(pushbutton_input));
  task automatic chk_light(input logic [3:0] e);
    n_tests++;
    if (light_output !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, light_output);
    end
  endtask
  task automatic chk_span(input int v, input int lo, input int hi);
    n_tests++;
    if (v < lo || v > hi) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h..%h got=%h", $time, lo, hi, v);
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic stop_test();
    $display("counts: tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run is near 8k clocks; six times that means a hang
  initial begin
    #(100 * 50000);
    n_fail++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h1b578c38));
    do_reset();
    chk_light(4'h0);
    // A press while the clock enable is low must leave no trace
    @(negedge clk);
    ce = 1'b0;
    u_stlc_button_model.press(1, 4);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    chk_light(4'h0);
    $display("test reset_and_hold done");
    // Random brief presses; each flips only its own channel
    exp_l = 4'h0;
    repeat (20) begin
      ch = $urandom % 4;
      exp_l[ch] = ~exp_l[ch];
      u_stlc_button_model.press(ch, 1 + $urandom % 4);
      chk_light(exp_l);
    end
    $display("test toggle done");
    // Timed switch-off; free-running minute gives one minute of slack
    do_reset();
    u_stlc_button_model.press(2, 1);
    u_stlc_button_model.on_time(2, 3000, n);
    chk_span(n, (AM - 1) * MD - 8, AM * MD + 4);
    chk_light(4'h0);
    $display("test auto_off done");
    // Long press: continuous light outlives the auto-off, then a brief press ends it
    u_stlc_button_model.press(0, 1100);
    repeat (700) @(negedge clk);
    chk_light(4'h1);
    u_stlc_button_model.press(0, 2);
    chk_light(4'h0);
    u_stlc_button_model.press(0, 2);
    u_stlc_button_model.on_time(0, 3000, n);
    chk_span(n, (AM - 1) * MD - 8, AM * MD + 4);
    $display("test continuous done");
    // Limit ends continuous light after its own span
    u_stlc_button_model.press(3, 1100);
    chk_light(4'h8);
    u_stlc_button_model.on_time(3, 3000, n);
    chk_span(n + 1103, (LM - 1) * MD - 8, LM * MD + 6);
    chk_light(4'h0);
    $display("test limit done");
    stop_test();
  end
endmodule // tb_top
